/* pipeline_model.sv */
// Pipeline model: program counters that follow trap redirects
module pipeline_model (
  input wire clock, // Core clock
  input wire rst_n, // Reset, active low
  input wire pc_load, // Redirect pulse
  input wire [31:0] pc_out, // Redirect target
  input wire [31:0] npc_out, // Redirect next target
  output logic [31:0] pc_in, // Current counter
  output logic [31:0] npc_in // Current next counter
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_in <= 32'h0;
      npc_in <= 32'h4;
    end
    else if (pc_load)
    begin
      pc_in <= pc_out;
      npc_in <= npc_out;
    end
    else
    begin
      pc_in <= npc_in;
      npc_in <= npc_in + 32'h4;
    end
  end
endmodule // pipeline_model

/* trap_control_asserts.sv */
// Port checker for the trap control unit
module trap_control_asserts #(
  parameter WINDOW_COUNT = 8
) (
  input wire clock, // Core clock
  input wire rst_n, // Reset, active low
  input wire pc_load, // Redirect pulse
  input wire [31:0] pc_out, // Redirect target
  input wire [31:0] npc_out, // Redirect next target
  input wire save_we, // Locals write pulse
  input wire [4:0] cwp_out, // Window pointer
  input wire supervisor_out, // Supervisor mode
  input wire halted, // Error state
  input wire reset_request, // Reset request out
  input wire fp_done, // Fp op done
  input wire fp_dest_we, // Fp commit
  input wire ext_reset_pin, // Reset request in
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire s_axi_rvalid, // Read valid
  input wire s_axi_rready, // Read ready
  input wire [31:0] s_axi_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  npc_step_a: assert property (pc_load |-> npc_out == pc_out + 32'h4)
    else $error("next pc not four past pc");
  vector_low_a: assert property (pc_load |-> pc_out[3:0] == 4'h0)
    else $error("handler address low bits set");
  save_entry_a: assert property (save_we |-> pc_load && supervisor_out)
    else $error("save without supervisor redirect");
  window_dec_a: assert property (save_we |->
    cwp_out == (($past(cwp_out) == 5'h0) ? WINDOW_COUNT - 1 : $past(cwp_out) - 5'h1))
    else $error("window pointer not decremented");
  halt_reset_a: assert property (halted |-> reset_request)
    else $error("halted without reset request");
  halt_skip_a: assert property ($rose(halted) |-> !pc_load && !save_we)
    else $error("trap actions on error entry");
  fp_commit_a: assert property (fp_dest_we |-> $past(fp_done) && !pc_load)
    else $error("fp commit without untrapped op");
  reset_trap_a: assert property ($rose(ext_reset_pin) |->
    ##[3:4] (pc_load && pc_out == 32'h0 && supervisor_out))
    else $error("reset trap missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // trap_control_asserts

bind trap_control_unit trap_control_asserts #(.WINDOW_COUNT(WINDOW_COUNT)) u_trap_control_asserts (
  .clock, .rst_n, .pc_load, .pc_out, .npc_out, .save_we, .cwp_out, .supervisor_out,
  .halted, .reset_request, .fp_done, .fp_dest_we, .ext_reset_pin, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* trap_control_defs.vh */
// Constants for the trap control unit: register map, fields, reset values, trap codes
`ifndef TRAP_CONTROL_DEFS_VH
`define TRAP_CONTROL_DEFS_VH

// Register byte offsets
`define OFS_TRAP_VECTOR_BASE 8'h00
`define OFS_STATE_WORD 8'h04
`define OFS_FP_STATUS 8'h08

// trap_vector_base fields
`define TBA_HI 31
`define TBA_LO 12
`define TT_HI 11
`define TT_LO 4
`define TBR_ZERO_BITS 4

// processor_state_word fields
`define PSW_CWP_HI 4
`define PSW_CWP_LO 0
`define PSW_ET 5
`define PSW_PS 6
`define PSW_S 7
`define PSW_PIL_HI 11
`define PSW_PIL_LO 8
`define PSW_ERR 12

// fp_status_word fields
`define FSW_TEM_HI 4
`define FSW_TEM_LO 0
`define FSW_AEXC_HI 9
`define FSW_AEXC_LO 5
`define FSW_FCC_HI 11
`define FSW_FCC_LO 10

// Reset values
`define RST_ET 1'b0
`define RST_S 1'b1
`define RST_TT 8'h00
`define RST_TBA 20'h00000
`define RST_CWP 5'h00
`define RST_PIL 4'h0

// Reset trap vector and next-PC step
`define RESET_PC 32'h00000000
`define PC_STEP 32'h00000004

// Hardware trap type codes
`define TT_STORE_ERR 8'h2B
`define TT_ITLB_MISS 8'h3C
`define TT_IACC_ERR 8'h21
`define TT_REG_ERR 8'h20
`define TT_IACC_EXC 8'h01
`define TT_PRIV 8'h03
`define TT_ILLEGAL 8'h02
`define TT_FP_DIS 8'h04
`define TT_CP_DIS 8'h24
`define TT_FLUSH 8'h25
`define TT_WATCH 8'h0B
`define TT_WIN_OVF 8'h05
`define TT_WIN_UNF 8'h06
`define TT_MISALIGN 8'h07
`define TT_FP_EXC 8'h08
`define TT_CP_EXC 8'h28
`define TT_DACC_ERR 8'h29
`define TT_DTLB_MISS 8'h2C
`define TT_DACC_EXC 8'h09
`define TT_TAG_OVF 8'h0A
`define TT_DIV_ZERO 8'h2A
`define TT_IMPL_BASE 3'h3
`define TT_SW_BIT 1'b1
`define TT_IRQ_BASE 4'h1
`define IRL_UNMASKABLE 4'hF

// Exception request vector layout, ordered by priority
`define NEXC 22
`define EXC_FP_EXC 14
`define EXC_IMPL 21

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* trap_control_unit.v */
// Trap control unit: trap ranking, trap entry, error mode, reset traps, register slave
// Function
// - A set trap-enable mask bit traps an IEEE exception; clear bit accrues it.
// - Trapping IEEE exception leaves destination, condition codes, accrued bits unchanged.
// - Trap base register holds the software-written upper 20 table address bits.
// - Every non-reset trap writes a unique 8-bit trap type code.
// - Low 4 register bits read zero; the whole register is the handler address.
// - Codes up to 0x7F are hardware traps; 0x80 and up are software traps.
// - Implementation exceptions use 0x60 to 0x7F; unassigned low codes never appear.
// - Trap type code holds until a later trap overwrites it.
// - Trap with traps disabled enters halted error state, skipping normal trap actions.
// - Entering error state writes code only for a trapping return-from-trap.
// - In error state the unit requests an external reset.
// - External reset request makes a reset trap: PC 0, next PC 4.
// - Reset trap initialises only trap enable and supervisor bits; the code also clears the error state bit and the reset request.
// - Reset trap leaves the trap type code as it was.
// - Only the pending request with lowest priority number is taken.
// - Priorities 1 to 7 use the fixed exception code table.
// - Priorities 8 to 15 use the fixed exception code table.
// - Software traps priority 16; interrupt level n priority 32-n, code 0x10+n.
// - Trap entry clears enable, saves mode, sets supervisor, rotates window, saves PCs.
// - Non-reset trap jumps to trap base register, next PC four beyond.
// - With traps disabled interrupts are ignored; precise exceptions enter the error state.
// - Interrupt taken when level exceeds mask level or equals 15.
`include "trap_control_defs.vh"

module trap_control_unit #(
  parameter WINDOW_COUNT = 8,
  parameter NEXC = `NEXC
) (
  input wire clock, // 50 MHz core clock
  input wire rst_n, // Asynchronous reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire [NEXC-1:0] exc_req, // Exception requests from pipeline
  input wire [4:0] impl_code, // Implementation exception number
  input wire sw_req, // Conditional trap instruction fired
  input wire [6:0] sw_num, // Software trap number
  input wire return_from_trap_instruction_active, // Requests stem from a return-from-trap
  input wire fp_done, // Floating-point op finished this cycle
  input wire [4:0] fp_ieee, // IEEE exceptions of that op
  input wire [1:0] fp_fcc_new, // Condition codes produced by that op
  input wire [31:0] pc_in, // Current program counter
  input wire [31:0] npc_in, // Current next program counter
  input wire [3:0] irl_pin, // Interrupt request level pins
  input wire ext_reset_pin, // External reset request pin
  output reg pc_load, // Pulse: load pc_out and npc_out
  output reg [31:0] pc_out, // New program counter
  output reg [31:0] npc_out, // New next program counter
  output reg save_we, // Pulse: write locals 17 and 18
  output reg [31:0] save_pc, // Value for local 17
  output reg [31:0] save_npc, // Value for local 18
  output reg fp_dest_we, // Pulse: commit fp destination register
  output reg halted, // Error state
  output reg reset_request, // Asks for external reset
  output reg [4:0] cwp_out, // Current window pointer
  output reg supervisor_out, // Supervisor mode
  input wire [7:0] s_axi_awaddr, // AXI write address
  input wire s_axi_awvalid, // AXI write address valid
  output reg s_axi_awready, // AXI write address ready
  input wire [31:0] s_axi_wdata, // AXI write data
  input wire [3:0] s_axi_wstrb, // AXI write strobes
  input wire s_axi_wvalid, // AXI write data valid
  output reg s_axi_wready, // AXI write data ready
  output reg [1:0] s_axi_bresp, // AXI write response
  output reg s_axi_bvalid, // AXI write response valid
  input wire s_axi_bready, // AXI write response ready
  input wire [7:0] s_axi_araddr, // AXI read address
  input wire s_axi_arvalid, // AXI read address valid
  output reg s_axi_arready, // AXI read address ready
  output reg [31:0] s_axi_rdata, // AXI read data
  output reg [1:0] s_axi_rresp, // AXI read response
  output reg s_axi_rvalid, // AXI read valid
  input wire s_axi_rready // AXI read ready
);

  function [31:0] byte_mask;
    input [3:0] strb;
    begin
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  function addr_known;
    input [7:0] a;
    begin
      if (a == `OFS_TRAP_VECTOR_BASE)
        addr_known = 1'b1;
      else if (a == `OFS_STATE_WORD)
        addr_known = 1'b1;
      else if (a == `OFS_FP_STATUS)
        addr_known = 1'b1;
      else
        addr_known = 1'b0;
    end
  endfunction

  // Architectural state
  reg [19:0] tba_q;
  reg [7:0] tt_q;
  reg et_q;
  reg ps_q;
  reg [4:0] cwp_q;
  reg [3:0] pil_q;
  reg [4:0] tem_q;
  reg [4:0] aexc_q;
  reg [1:0] fcc_q;

  // Pin synchronisers
  reg [3:0] irl_meta_q;
  reg [3:0] irl_q;
  reg rst_meta_q;
  reg rst_sync_q;
  reg rst_prev_q;

  // Bus state
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [31:0] tbr_value = {tba_q, tt_q, {`TBR_ZERO_BITS{1'b0}}};
  wire [31:0] psw_value = {19'h00000, halted, pil_q, supervisor_out, ps_q, et_q, cwp_q};
  wire [31:0] fsw_value = {20'h00000, fcc_q, aexc_q, tem_q};

  // Masked IEEE exception joins the pipeline's own fp fault
  wire fp_trap = fp_done & |(fp_ieee & tem_q);
  wire [NEXC-1:0] exc_all = exc_req | ({{(NEXC-1){1'b0}}, fp_trap} << `EXC_FP_EXC);

  wire win_hit;
  wire win_precise;
  wire [7:0] win_code;

  trap_prioritizer #(
    .NEXC(NEXC)
  ) u_prio (
    .exc_req(exc_all),
    .impl_code(impl_code),
    .sw_req(sw_req),
    .sw_num(sw_num),
    .irl(irl_q),
    .processor_interrupt_level(pil_q),
    .irq_en(et_q),
    .hit(win_hit),
    .precise(win_precise),
    .code(win_code)
  );

  wire reset_trap = rst_sync_q & ~rst_prev_q;
  wire take_trap = ~reset_trap & ~halted & win_hit & et_q;
  wire go_error = ~reset_trap & ~halted & win_precise & ~et_q;
  wire [4:0] cwp_dec = (cwp_q == 5'h00) ? WINDOW_COUNT[4:0] - 5'h01 : cwp_q - 5'h01;

  // Software register writes; a trap or reset trap drops the whole state word write, fp commit overrides accrued bits and fcc
  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] wmask = byte_mask(w_strb_q);
  wire wr_tbr = wr_fire & (aw_addr_q == `OFS_TRAP_VECTOR_BASE);
  wire wr_psw = wr_fire & (aw_addr_q == `OFS_STATE_WORD);
  wire wr_fsw = wr_fire & (aw_addr_q == `OFS_FP_STATUS);
  wire [31:0] tbr_new = (tbr_value & ~wmask) | (w_data_q & wmask);
  wire [31:0] psw_new = (psw_value & ~wmask) | (w_data_q & wmask);
  wire [31:0] fsw_new = (fsw_value & ~wmask) | (w_data_q & wmask);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irl_meta_q <= 4'h0;
      irl_q <= 4'h0;
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      irl_meta_q <= irl_pin;
      irl_q <= irl_meta_q;
      rst_meta_q <= ext_reset_pin;
      rst_sync_q <= rst_meta_q;
      rst_prev_q <= rst_sync_q;
    end
  end

  // Trap sequencing and architectural registers
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tba_q <= `RST_TBA;
      tt_q <= `RST_TT;
      et_q <= `RST_ET;
      supervisor_out <= `RST_S;
      ps_q <= 1'b0;
      cwp_q <= `RST_CWP;
      pil_q <= `RST_PIL;
      tem_q <= 5'h00;
      aexc_q <= 5'h00;
      fcc_q <= 2'h0;
      halted <= 1'b0;
      reset_request <= 1'b0;
      pc_load <= 1'b0;
      pc_out <= `RESET_PC;
      npc_out <= `RESET_PC;
      save_we <= 1'b0;
      save_pc <= 32'h00000000;
      save_npc <= 32'h00000000;
      fp_dest_we <= 1'b0;
      cwp_out <= `RST_CWP;
    end
    else if (ce)
    begin
      pc_load <= 1'b0;
      save_we <= 1'b0;
      fp_dest_we <= 1'b0;
      if (wr_tbr)
        tba_q <= tbr_new[`TBA_HI:`TBA_LO];
      if (wr_fsw)
      begin
        tem_q <= fsw_new[`FSW_TEM_HI:`FSW_TEM_LO];
        aexc_q <= fsw_new[`FSW_AEXC_HI:`FSW_AEXC_LO];
        fcc_q <= fsw_new[`FSW_FCC_HI:`FSW_FCC_LO];
      end
      if (wr_psw & ~reset_trap & ~take_trap)
      begin
        cwp_q <= psw_new[`PSW_CWP_HI:`PSW_CWP_LO];
        cwp_out <= psw_new[`PSW_CWP_HI:`PSW_CWP_LO];
        et_q <= psw_new[`PSW_ET];
        ps_q <= psw_new[`PSW_PS];
        supervisor_out <= psw_new[`PSW_S];
        pil_q <= psw_new[`PSW_PIL_HI:`PSW_PIL_LO];
      end
      // Untrapped fp result commits; a trapped one leaves everything alone
      if (fp_done & ~fp_trap & ~halted & ~reset_trap)
      begin
        aexc_q <= aexc_q | fp_ieee;
        fcc_q <= fp_fcc_new;
        fp_dest_we <= 1'b1;
      end
      if (reset_trap)
      begin
        // Trap type code deliberately untouched
        et_q <= 1'b0;
        supervisor_out <= 1'b1;
        halted <= 1'b0;
        reset_request <= 1'b0;
        pc_out <= `RESET_PC;
        npc_out <= `RESET_PC + `PC_STEP;
        pc_load <= 1'b1;
      end
      else if (take_trap)
      begin
        tt_q <= win_code;
        et_q <= 1'b0;
        ps_q <= supervisor_out;
        supervisor_out <= 1'b1;
        cwp_q <= cwp_dec;
        cwp_out <= cwp_dec;
        save_pc <= pc_in;
        save_npc <= npc_in;
        save_we <= 1'b1;
        pc_out <= {tba_q, win_code, {`TBR_ZERO_BITS{1'b0}}};
        npc_out <= {tba_q, win_code, {`TBR_ZERO_BITS{1'b0}}} + `PC_STEP;
        pc_load <= 1'b1;
      end
      else if (go_error)
      begin
        // Window, mode and saved counters stay as they are
        halted <= 1'b1;
        reset_request <= 1'b1;
        if (return_from_trap_instruction_active)
          tt_q <= win_code;
      end
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid & ~aw_have_q & ~s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & ~w_have_q & ~s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid)
      begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid & ~s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if ({s_axi_araddr[7:2], 2'b00} == `OFS_TRAP_VECTOR_BASE)
          s_axi_rdata <= tbr_value;
        else if ({s_axi_araddr[7:2], 2'b00} == `OFS_STATE_WORD)
          s_axi_rdata <= psw_value;
        else if ({s_axi_araddr[7:2], 2'b00} == `OFS_FP_STATUS)
          s_axi_rdata <= fsw_value;
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
    end
  end

endmodule // trap_control_unit

/* trap_control_unit_tb_top.sv */
// Testbench for the trap control unit
module trap_control_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0, rst_n = 1'h0, sw_req = 1'h0, return_from_trap_instruction_active = 1'h0, fp_done = 1'h0;
  logic ext_reset_pin = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, got, sb, fd;
  logic [21:0] exc_req = 22'h0, e;
  logic [4:0] impl_code = 5'h0, fp_ieee = 5'h0, cn;
  logic [6:0] sw_num = 7'h0;
  logic [1:0] fp_fcc_new = 2'h0, rr, br;
  logic [3:0] irl_pin = 4'h0, pl;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, code;
  logic [31:0] s_axi_wdata = 32'h0, trap_table_base, rd, c_pc, c_npc, c_save, s_pc, c_snpc, s_npc;
  wire [31:0] pc_in, npc_in, pc_out, npc_out, save_pc, save_npc, s_axi_rdata;
  wire [4:0] cwp_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire pc_load, save_we, fp_dest_we, halted, reset_request, supervisor_out;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0, samples_checked = 0;
  logic [7:0] codes [0:20] = '{8'h2B, 8'h3C, 8'h21, 8'h20, 8'h01, 8'h03, 8'h02, 8'h04,
    8'h24, 8'h25, 8'h0B, 8'h05, 8'h06, 8'h07, 8'h08, 8'h28, 8'h29, 8'h2C, 8'h09, 8'h0A, 8'h2A};

  always #10 clock = ~clock;

  trap_control_unit #(.WINDOW_COUNT(8)) u_trap_control_unit (.clock, .rst_n, .ce(1'h1),
    .exc_req, .impl_code, .sw_req, .sw_num, .return_from_trap_instruction_active, .fp_done, .fp_ieee, .fp_fcc_new,
    .pc_in, .npc_in, .irl_pin, .ext_reset_pin, .pc_load, .pc_out, .npc_out, .save_we,
    .save_pc, .save_npc, .fp_dest_we, .halted, .reset_request, .cwp_out, .supervisor_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pipeline_model u_pipeline_model (.clock, .rst_n, .pc_load, .pc_out, .npc_out, .pc_in, .npc_in);

  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      $display("unexpected %s expected %h seen %h", nm, x, s);
      n_mismatch++;
    end
  endtask

  task hang(input logic ok);
    if (ok !== 1'h1)
    begin
      n_mismatch++;
      summarize;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 1'h0;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      done = s_axi_bvalid;
      br = s_axi_bresp;
    end
    s_axi_bready <= 1'h0;
    hang(done);
  endtask

  task rdr(input logic [7:0] a);
    logic done;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 1'h0;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
    end
    s_axi_rready <= 1'h0;
    hang(done);
  endtask

  // Enable traps with a chosen window, mode and mask level
  task arm(input logic [3:0] p, input logic [4:0] c, input logic s);
    wr(8'h04, {20'h0, p, s, 1'h0, 1'h1, c});
  endtask

  // Requests last one edge; pins stay up until a redirect or the bound
  task fire(input logic [21:0] x, input logic s, input logic [3:0] irl, input logic r,
    input logic f);
    @(posedge clock);
    exc_req <= x;
    sw_req <= s;
    irl_pin <= irl;
    ext_reset_pin <= r;
    fp_done <= f;
    @(posedge clock);
    s_pc = pc_in;
    s_npc = npc_in;
    exc_req <= 22'h0;
    sw_req <= 1'h0;
    fp_done <= 1'h0;
    got = 1'h0;
    fd = 1'h0;
    for (int n = 0; n < 8 && !got; n++)
    begin
      @(posedge clock);
      got = pc_load;
      c_pc = pc_out;
      c_npc = npc_out;
      c_save = save_pc;
      c_snpc = save_npc;
      fd = fd | fp_dest_we;
    end
    irl_pin <= 4'h0;
    ext_reset_pin <= 1'h0;
  endtask

  initial
  begin
    void'($urandom(32'h660A));
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    rdr(8'h00);
    chk("vector base reset", rd, 32'h0);
    rdr(8'h04);
    chk("state reset", rd, 32'h80);
    rdr(8'h0C);
    chk("unmapped resp", rr, 2'h2);
    chk("unmapped data", rd, 32'h0);
    wr(8'h0C, 32'h0);
    chk("unmapped wresp", br, 2'h2);
    trap_table_base = $urandom;
    wr(8'h00, trap_table_base);
    chk("write resp", br, 2'h0);
    trap_table_base[11:0] = 12'h0;
    rdr(8'h00);
    chk("table base", rd, trap_table_base);
    $display("test registers done");
    for (int i = 0; i < 22; i++)
    begin
      impl_code <= 5'($urandom);
      pl = 4'($urandom);
      cn = 5'($urandom_range(7));
      sb = 1'($urandom);
      arm(pl, cn, sb);
      e = 22'($urandom << i) | (22'h1 << i);
      code = (i == 21) ? {3'h3, impl_code} : codes[i];
      fire(e, 1'($urandom), 4'h0, 1'h0, 1'h0);
      chk("taken", got, 1'h1);
      chk("trap pc", c_pc, trap_table_base | {code, 4'h0});
      chk("trap npc", c_npc, (trap_table_base | {code, 4'h0}) + 32'h4);
      chk("saved pc", c_save, s_pc);
      chk("saved npc", c_snpc, s_npc);
      cn = (cn + 5'h7) % 5'h8;
      chk("window", cwp_out, cn);
      rdr(8'h04);
      chk("state", rd, {20'h0, pl, 1'h1, sb, 1'h0, cn});
      rdr(8'h00);
      chk("trap code", rd[11:4], code);
    end
    $display("test exceptions done");
    sw_num <= 7'($urandom);
    arm(4'h0, 5'h2, 1'h1);
    fire(22'h0, 1'h1, 4'hF, 1'h0, 1'h0);
    chk("soft code", c_pc[11:4], {1'h1, sw_num});
    for (int lv = 1; lv < 16; lv++)
    begin
      arm(4'(lv - 1), 5'h1, 1'h0);
      fire(22'h0, 1'h0, 4'(lv), 1'h0, 1'h0);
      chk("irq code", c_pc[11:4], 8'h10 + 8'(lv));
    end
    arm(4'h9, 5'h1, 1'h0);
    fire(22'h0, 1'h0, 4'h9, 1'h0, 1'h0);
    chk("masked irq", got, 1'h0);
    $display("test interrupts done");
    wr(8'h04, 32'h80);
    fire(22'h20, 1'h0, 4'h0, 1'h0, 1'h0);
    chk("error trap", got, 1'h0);
    chk("halted", halted, 1'h1);
    chk("reset req", reset_request, 1'h1);
    chk("error window", cwp_out, 5'h0);
    rdr(8'h00);
    chk("error code", rd[11:4], 8'h1F);
    fire(22'h0, 1'h0, 4'h0, 1'h1, 1'h0);
    chk("reset pc", c_pc, 32'h0);
    chk("reset npc", c_npc, 32'h4);
    chk("unhalted", halted, 1'h0);
    rdr(8'h00);
    chk("reset code", rd[11:4], 8'h1F);
    rdr(8'h04);
    chk("reset state", {rd[12], rd[7], rd[5]}, 3'h2);
    fire(22'h0, 1'h0, 4'hF, 1'h0, 1'h0);
    chk("irq disabled", got, 1'h0);
    return_from_trap_instruction_active <= 1'h1;
    fire(22'h40, 1'h0, 4'h0, 1'h0, 1'h0);
    return_from_trap_instruction_active <= 1'h0;
    rdr(8'h00);
    chk("return code", rd[11:4], 8'h02);
    fire(22'h0, 1'h0, 4'h0, 1'h1, 1'h0);
    $display("test error mode done");
    wr(8'h08, 32'h1);
    fp_ieee <= 5'h02;
    fp_fcc_new <= 2'h3;
    fire(22'h0, 1'h0, 4'h0, 1'h0, 1'h1);
    rdr(8'h08);
    chk("fp accrued", rd, 32'hC41);
    chk("fp commit", fd, 1'h1);
    fp_ieee <= 5'h01;
    fp_fcc_new <= 2'h0;
    arm(4'h0, 5'h4, 1'h1);
    fire(22'h0, 1'h0, 4'h0, 1'h0, 1'h1);
    chk("fp trap", c_pc[11:4], 8'h08);
    chk("fp no commit", fd, 1'h0);
    rdr(8'h08);
    chk("fp kept", rd, 32'hC41);
    $display("test float done");
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    rdr(8'h04);
    chk("state rereset", rd, 32'h80);
    $display("test second reset done");
    summarize;
  end
endmodule // trap_control_unit_tb_top

/* trap_prioritizer.v */
// Fixed priority selection among exceptions, software traps and interrupts
`include "trap_control_defs.vh"

module trap_prioritizer #(
  parameter NEXC = `NEXC
) (
  input wire [NEXC-1:0] exc_req, // Exceptions, bit 0 highest priority
  input wire [4:0] impl_code, // Low bits of implementation code
  input wire sw_req, // Conditional trap instruction fired
  input wire [6:0] sw_num, // Software trap number
  input wire [3:0] irl, // Synchronised interrupt level
  input wire [3:0] processor_interrupt_level, // Processor interrupt level
  input wire irq_en, // Traps enabled
  output wire hit, // Some request wins
  output wire precise, // Winner is not an interrupt
  output wire [7:0] code // Winner trap type
);

  function [7:0] exc_code;
    input integer idx;
    begin
      case (idx)
        0: exc_code = `TT_STORE_ERR;
        1: exc_code = `TT_ITLB_MISS;
        2: exc_code = `TT_IACC_ERR;
        3: exc_code = `TT_REG_ERR;
        4: exc_code = `TT_IACC_EXC;
        5: exc_code = `TT_PRIV;
        6: exc_code = `TT_ILLEGAL;
        7: exc_code = `TT_FP_DIS;
        8: exc_code = `TT_CP_DIS;
        9: exc_code = `TT_FLUSH;
        10: exc_code = `TT_WATCH;
        11: exc_code = `TT_WIN_OVF;
        12: exc_code = `TT_WIN_UNF;
        13: exc_code = `TT_MISALIGN;
        14: exc_code = `TT_FP_EXC;
        15: exc_code = `TT_CP_EXC;
        16: exc_code = `TT_DACC_ERR;
        17: exc_code = `TT_DTLB_MISS;
        18: exc_code = `TT_DACC_EXC;
        19: exc_code = `TT_TAG_OVF;
        20: exc_code = `TT_DIV_ZERO;
        default: exc_code = 8'h00;
      endcase
    end
  endfunction

  wire [NEXC:0] seen;
  wire [7:0] part [0:NEXC];
  wire irq_hit;
  assign seen[0] = 1'b0;
  assign part[0] = 8'h00;

  // Lowest index wins; equal priorities resolve by index
  genvar i;
  generate
    for (i = 0; i < NEXC; i = i + 1)
    begin : g_sel
      wire win = exc_req[i] & ~seen[i];
      wire [7:0] c = (i == `EXC_IMPL) ? {`TT_IMPL_BASE, impl_code} : exc_code(i);
      assign seen[i+1] = seen[i] | exc_req[i];
      assign part[i+1] = part[i] | (win ? c : 8'h00);
    end
  endgenerate

  // Interrupts only while enabled; level 15 ignores the mask
  assign irq_hit = irq_en & (irl != 4'h0) & ((irl > processor_interrupt_level) | (irl == `IRL_UNMASKABLE));
  assign precise = seen[NEXC] | sw_req;
  assign hit = precise | irq_hit;
  assign code = seen[NEXC] ? part[NEXC] :
    sw_req ? {`TT_SW_BIT, sw_num} :
    {`TT_IRQ_BASE, irl};

endmodule // trap_prioritizer
